// ===== shared/mdsc_defines.svh
// register offsets, field positions, reset values and timing counts of the modem control block
`ifndef MDSC_DEFINES_SVH
`define MDSC_DEFINES_SVH

// register offsets (seven-bit address of the serial frame)
`define MDSC_ADDR_CFG        7'h00
`define MDSC_ADDR_MUX        7'h01
`define MDSC_ADDR_SCAN       7'h02
`define MDSC_ADDR_TXRX       7'h03
`define MDSC_ADDR_STATUS     7'h07

// configuration register fields
`define MDSC_CFG_OSC_KEEP    7
`define MDSC_CFG_POWER_DOWN  6
`define MDSC_CFG_STANDBY     5
`define MDSC_CFG_TX_ON       4
`define MDSC_CFG_RATE_HI     1
`define MDSC_CFG_RATE_LO     0

// scan control register fields
`define MDSC_SCAN_START      7
`define MDSC_SCAN_ACTIVE     6
`define MDSC_SCAN_PORT_HI    5
`define MDSC_SCAN_PORT_LO    4

// reset values
`define MDSC_CFG_RST         8'h80
`define MDSC_MUX_RST         3'h0
`define MDSC_MASK_RST        4'hF
`define MDSC_TX_POWER_RST    4'h7
`define MDSC_RXSENS_RST      4'hB

// timing: clock period and bit times in picoseconds
`define MDSC_CLK_PERIOD_PS   20000
`define MDSC_BIT_TIME_9K6_PS 104160000
`define MDSC_BIT_TIME_38K_PS 26040000
`define MDSC_BIT_TIME_115K_PS 8680000
`define MDSC_DIR_DWELL_BITS  5'h10
`define MDSC_SCAN_DWELL_BITS 5'h10
`define MDSC_SPI_FRAME_BITS  5'h10

`endif

// ===== shared/mdsc_pkg.sv
// types of the modem control block
package mdsc_pkg;

    // direction state machine
    typedef enum logic [1:0] {
        DIR_IDLE = 2'b00,
        DIR_RECV = 2'b01,
        DIR_HOLD = 2'b10,
        DIR_SEND = 2'b11
    } mdsc_dir_t;

    // port scan engine
    typedef enum logic [0:0] {
        SCAN_IDLE   = 1'b0,
        SCAN_LISTEN = 1'b1
    } mdsc_scan_t;

endpackage : mdsc_pkg

// ===== rtl/mdsc_sync3.sv
// three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ps
module mdsc_sync3 #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // async in, filtered out
    input  wire logic [W-1:0] d_async,
    output      logic [W-1:0] q
);

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1)
        begin : g_bit
            logic s1_r;
            logic s2_r;
            logic s3_r;
            // first stage feeds only the second; change accepted when stages 2 and 3 agree
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    s1_r <= RST_VAL[g];
                    s2_r <= RST_VAL[g];
                    s3_r <= RST_VAL[g];
                    q[g] <= RST_VAL[g];
                end
                else
                begin
                    s1_r <= d_async[g];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r)
                        q[g] <= s3_r;
                end
            end
        end
    endgenerate

endmodule : mdsc_sync3

// ===== rtl/mdsc_ctrl.sv
// modem control: serial register port, transmit gating, direction output, power modes, port scan
// Notes on behaviour
// - power code output is code times 0.5 dB minus 0.5 dBm; resets to 7.
// - carrier-tone bit set forces a continuous carrier without any transmit data.
// - direction output high while data flows from the radio port to receive output.
// - direction output low while data flows from transmit input to the radio port.
// - direction logic watches transmit input and detector so own transmission never raises direction.
// - direction stays high sixteen bit times after the last received low bit.
// - bit time from rate code: 9.6, 38.4 or 115.2 kbps; code 3 has none.
// - registers are programmed over a four-wire serial port; reads return data on serial out.
// - leading selector bit zero writes, one reads.
// - serial port and register contents survive standby and power-down.
// - standby turns off the whole transmit chain, receiver and direction keep working.
// - power-down turns off transmit and receive chains, receive output and direction.
// - oscillator-keep resets to one and keeps oscillator and sync output running in power-down.
// - oscillator-keep zero with power-down also stops oscillator and sync output.
// - port scanning is configured from the scan register at offset 0x02.
// - mask bit one includes a port in the scan; mask resets to all four ports.
// - writing one to scan-launch starts scanning; the bit clears itself and reads zero.
// - while scanning, active flag is one and listened-port shows the connected port.
// - carrier sent when transmit input low or tone bit set, otherwise none.
// - detected carrier drives receive output low and, unless transmitting, direction high.
// - scan visits unmasked ports in ascending order, steering the multiplexer to each.
`timescale 1ns/1ps
`include "mdsc_defines.svh"
module mdsc_ctrl #(
    parameter logic [12:0] BIT_CYC_9K6 = 13'(`MDSC_BIT_TIME_9K6_PS / `MDSC_CLK_PERIOD_PS)
) (
    // clock and reset
    input  wire logic       CLOCK,
    input  wire logic       RESET,
    // serial register port
    input  wire logic       SCLK,
    input  wire logic       SDI,
    input  wire logic       CHIP_SELECT_N,
    output      logic       SDO,
    output      logic       SDO_OE,
    // modem data pins
    input  wire logic       TX_DATA_IN,
    input  wire logic       RX_DETECT,
    output      logic       RX_DATA_OUT,
    output      logic       DIR,
    // analog front-end controls
    output      logic       TX_CARRIER,
    output      logic [3:0] TX_POWER_CODE,
    output      logic [3:0] RX_SENS_CODE,
    output      logic [1:0] MUX_PORT,
    output      logic       MUX_OPEN,
    output      logic       TX_CHAIN_ENABLE,
    output      logic       RX_CHAIN_ENABLE,
    output      logic       OSC_ENABLE,
    output      logic       CLOCK_SYNC_OUTPUT_ENABLE
);

    localparam logic [12:0] BIT_CYC_38K4  = 13'(`MDSC_BIT_TIME_38K_PS / `MDSC_CLK_PERIOD_PS);
    localparam logic [12:0] BIT_CYC_115K2 = 13'(`MDSC_BIT_TIME_115K_PS / `MDSC_CLK_PERIOD_PS);

    // bit period in clocks; zero marks the reserved code
    function automatic logic [12:0] bit_cycles(input logic [1:0] rate);
        case (rate)
            2'h0:    bit_cycles = BIT_CYC_9K6;
            2'h1:    bit_cycles = BIT_CYC_38K4;
            2'h2:    bit_cycles = BIT_CYC_115K2;
            default: bit_cycles = 13'h0000;
        endcase
    endfunction : bit_cycles

    // lowest unmasked port at or above start; msb flags a hit
    function automatic logic [2:0] first_port(input logic [3:0] mask, input logic [2:0] start);
        first_port = 3'h0;
        for (int i = 3; i >= 0; i--)
            if (i >= int'(start) && mask[i])
                first_port = {1'b1, 2'(i)};
    endfunction : first_port

    // pin inputs through the agreement synchroniser
    logic [4:0] pins_s;
    mdsc_sync3 #(.W(5), .RST_VAL(5'h0C)) u_sync (
        .clk     (CLOCK),
        .rst     (RESET),
        .d_async ({RX_DETECT, TX_DATA_IN, CHIP_SELECT_N, SDI, SCLK}),
        .q       (pins_s)
    );
    wire sclk_s = pins_s[0];
    wire sdi_s  = pins_s[1];
    wire csn_s  = pins_s[2];
    wire txd_s  = pins_s[3];
    wire det_s  = pins_s[4];

    // register state
    logic [7:0] cfg_r;
    logic [2:0] mux_r;
    logic [3:0] tx_power_code_r;
    logic [3:0] rx_sens_r;
    logic [3:0] port_include_mask_r;
    logic       scan_start_r;
    mdsc_pkg::mdsc_scan_t scan_st_r;
    logic [1:0] scan_port_r;
    mdsc_pkg::mdsc_dir_t  dir_st_r;

    // serial port state
    logic       sclk_d_r;
    logic [4:0] spi_cnt_r;
    logic [14:0] spi_sh_r;
    logic [7:0] sdo_sh_r;
    logic       rd_phase_r;

    // configuration decode
    wire       osc_keep_alive = cfg_r[`MDSC_CFG_OSC_KEEP];
    wire       power_down_bit = cfg_r[`MDSC_CFG_POWER_DOWN];
    wire       standby_bit    = cfg_r[`MDSC_CFG_STANDBY];
    wire       tx_on_bit      = cfg_r[`MDSC_CFG_TX_ON];
    wire [1:0] bit_rate_select = cfg_r[`MDSC_CFG_RATE_HI:`MDSC_CFG_RATE_LO];
    wire       tx_enable_w    = !standby_bit && !power_down_bit;
    wire       rx_enable_w    = !power_down_bit;
    wire       tx_active_w    = tx_enable_w && (!txd_s || tx_on_bit);
    wire       det_w          = rx_enable_w && det_s;
    wire       scanning_w     = (scan_st_r == mdsc_pkg::SCAN_LISTEN);

    // serial frame decode; edges taken on filtered clock so the port runs in every mode
    wire        sclk_rise = sclk_s && !sclk_d_r;
    wire        sclk_fall = !sclk_s && sclk_d_r;
    wire        rd_load_w = !csn_s && sclk_rise && spi_cnt_r == 5'h07 && spi_sh_r[6];
    wire [6:0]  rd_addr_w = {spi_sh_r[5:0], sdi_s};
    wire        wr_w      = !csn_s && sclk_rise && spi_cnt_r == `MDSC_SPI_FRAME_BITS - 5'h01
                            && !spi_sh_r[14];
    wire [6:0]  wr_addr_w = spi_sh_r[13:7];
    wire [7:0]  wr_data_w = {spi_sh_r[6:0], sdi_s};
    wire        wr_cfg_w  = wr_w && wr_addr_w == `MDSC_ADDR_CFG;
    wire        wr_mux_w  = wr_w && wr_addr_w == `MDSC_ADDR_MUX;
    wire        wr_scan_w = wr_w && wr_addr_w == `MDSC_ADDR_SCAN;
    wire        wr_txrx_w = wr_w && wr_addr_w == `MDSC_ADDR_TXRX;
    wire [7:0]  status_w  = {5'h00, tx_active_w, DIR, RX_DATA_OUT};

    // read mux; launch bit always reads zero, unmapped reads zero
    logic [7:0] rd_data_w;
    always_comb
    begin
        case (rd_addr_w)
            `MDSC_ADDR_CFG:    rd_data_w = cfg_r;
            `MDSC_ADDR_MUX:    rd_data_w = {5'h00, mux_r};
            `MDSC_ADDR_SCAN:   rd_data_w = {1'b0, scanning_w, scan_port_r, port_include_mask_r};
            `MDSC_ADDR_TXRX:   rd_data_w = {rx_sens_r, tx_power_code_r};
            `MDSC_ADDR_STATUS: rd_data_w = status_w;
            default:           rd_data_w = 8'h00;
        endcase
    end

    // serial shifter: sample on rising, drive read data on falling
    always_ff @(posedge CLOCK)
    begin
        if (RESET || csn_s)
        begin
            spi_cnt_r  <= 5'h00;
            spi_sh_r   <= 15'h0000;
            rd_phase_r <= 1'b0;
            sdo_sh_r   <= 8'h00;
            SDO        <= 1'b0;
        end
        else
        begin
            if (sclk_rise && spi_cnt_r != `MDSC_SPI_FRAME_BITS)
            begin
                spi_cnt_r <= spi_cnt_r + 5'h01;
                spi_sh_r  <= {spi_sh_r[13:0], sdi_s};
            end
            if (rd_load_w)
            begin
                rd_phase_r <= 1'b1;
                sdo_sh_r   <= rd_data_w;
            end
            else if (sclk_fall && rd_phase_r)
            begin
                SDO      <= sdo_sh_r[7];
                sdo_sh_r <= {sdo_sh_r[6:0], 1'b0};
            end
        end
    end

    // sdo driven only through the data phase of a read
    always_ff @(posedge CLOCK)
    begin
        sclk_d_r <= RESET ? 1'b0 : sclk_s;
        SDO_OE   <= !RESET && !csn_s && rd_phase_r;
    end

    // register writes; contents kept in every power mode
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            cfg_r               <= `MDSC_CFG_RST;
            mux_r               <= `MDSC_MUX_RST;
            tx_power_code_r     <= `MDSC_TX_POWER_RST;
            rx_sens_r           <= `MDSC_RXSENS_RST;
            port_include_mask_r <= `MDSC_MASK_RST;
            scan_start_r        <= 1'b0;
        end
        else
        begin
            if (wr_cfg_w)
                cfg_r <= wr_data_w;
            if (wr_mux_w)
                mux_r <= wr_data_w[2:0];
            if (wr_txrx_w)
                {rx_sens_r, tx_power_code_r} <= wr_data_w;
            if (wr_scan_w)
                port_include_mask_r <= wr_data_w[3:0];
            scan_start_r <= wr_scan_w && wr_data_w[`MDSC_SCAN_START];
        end
    end

    // direction state machine and its dwell counter
    wire [12:0] dir_per_w = bit_cycles(bit_rate_select);
    logic [12:0] hold_cyc_r;
    logic [4:0]  hold_bits_r;
    mdsc_pkg::mdsc_dir_t dir_st_nxt;
    wire hold_tick_w = hold_cyc_r == dir_per_w - 13'h0001;
    wire hold_done_w = hold_bits_r == `MDSC_DIR_DWELL_BITS || dir_per_w == 13'h0000;

    always_comb
    begin
        dir_st_nxt = dir_st_r;
        case (dir_st_r)
            mdsc_pkg::DIR_IDLE:
                if (tx_active_w)
                    dir_st_nxt = mdsc_pkg::DIR_SEND;
                else if (det_w)
                    dir_st_nxt = mdsc_pkg::DIR_RECV;
            mdsc_pkg::DIR_SEND:
                if (!tx_active_w)
                    dir_st_nxt = mdsc_pkg::DIR_IDLE;
            mdsc_pkg::DIR_RECV:
                if (!det_w)
                    dir_st_nxt = mdsc_pkg::DIR_HOLD;
            mdsc_pkg::DIR_HOLD:
                if (det_w)
                    dir_st_nxt = mdsc_pkg::DIR_RECV;
                else if (hold_done_w)
                    dir_st_nxt = mdsc_pkg::DIR_IDLE;
            default:
                dir_st_nxt = mdsc_pkg::DIR_IDLE;
        endcase
        if (power_down_bit)
            dir_st_nxt = mdsc_pkg::DIR_IDLE;
    end

    // dwell restarts from the last low bit so every hold outside power-down and rate code 3 is a full sixteen bits
    always_ff @(posedge CLOCK)
    begin
        if (RESET || dir_st_r != mdsc_pkg::DIR_HOLD)
        begin
            hold_cyc_r  <= 13'h0000;
            hold_bits_r <= 5'h00;
        end
        else
        begin
            hold_cyc_r  <= hold_tick_w ? 13'h0000 : hold_cyc_r + 13'h0001;
            hold_bits_r <= hold_tick_w ? hold_bits_r + 5'h01 : hold_bits_r;
        end
        dir_st_r <= RESET ? mdsc_pkg::DIR_IDLE : dir_st_nxt;
    end

    // scan engine: ascending walk over unmasked ports, sixteen bit times each
    logic [12:0] scan_cyc_r;
    logic [4:0]  scan_bits_r;
    wire scan_tick_w = scan_cyc_r == dir_per_w - 13'h0001;
    wire scan_adv_w  = scan_bits_r == `MDSC_SCAN_DWELL_BITS;
    wire [2:0] launch_w = first_port(port_include_mask_r, 3'h0);
    wire [2:0] next_w   = first_port(port_include_mask_r, {1'b0, scan_port_r} + 3'h1);

    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            scan_st_r   <= mdsc_pkg::SCAN_IDLE;
            scan_port_r <= 2'h0;
        end
        else if (scan_start_r && launch_w[2])
        begin
            scan_st_r   <= mdsc_pkg::SCAN_LISTEN;
            scan_port_r <= launch_w[1:0];
        end
        else if (scanning_w && scan_adv_w)
        begin
            scan_st_r   <= next_w[2] ? mdsc_pkg::SCAN_LISTEN : mdsc_pkg::SCAN_IDLE;
            scan_port_r <= next_w[2] ? next_w[1:0] : scan_port_r;
        end
    end

    // dwell counter; reserved rate wraps the bit period to 8192 clocks, so each port dwells 16 of those
    always_ff @(posedge CLOCK)
    begin
        if (RESET || !scanning_w || scan_adv_w || scan_start_r)
        begin
            scan_cyc_r  <= 13'h0000;
            scan_bits_r <= 5'h00;
        end
        else
        begin
            scan_cyc_r  <= scan_tick_w ? 13'h0000 : scan_cyc_r + 13'h0001;
            scan_bits_r <= scan_tick_w ? scan_bits_r + 5'h01 : scan_bits_r;
        end
    end

    // registered outputs to the pins and analog blocks
    always_ff @(posedge CLOCK)
    begin
        if (RESET)
        begin
            TX_CARRIER               <= 1'b0;
            RX_DATA_OUT              <= 1'b1;
            DIR                      <= 1'b0;
            TX_POWER_CODE            <= `MDSC_TX_POWER_RST;
            RX_SENS_CODE             <= `MDSC_RXSENS_RST;
            MUX_PORT                 <= 2'h0;
            MUX_OPEN                 <= 1'b0;
            TX_CHAIN_ENABLE          <= 1'b1;
            RX_CHAIN_ENABLE          <= 1'b1;
            OSC_ENABLE               <= 1'b1;
            CLOCK_SYNC_OUTPUT_ENABLE <= 1'b1;
        end
        else
        begin
            TX_CARRIER               <= tx_active_w;
            RX_DATA_OUT              <= !det_w;
            DIR                      <= dir_st_nxt == mdsc_pkg::DIR_RECV
                                        || dir_st_nxt == mdsc_pkg::DIR_HOLD;
            TX_POWER_CODE            <= tx_power_code_r;
            RX_SENS_CODE             <= rx_sens_r;
            MUX_PORT                 <= scanning_w ? scan_port_r : mux_r[1:0];
            MUX_OPEN                 <= mux_r[2];
            TX_CHAIN_ENABLE          <= tx_enable_w;
            RX_CHAIN_ENABLE          <= rx_enable_w;
            OSC_ENABLE               <= !power_down_bit || osc_keep_alive;
            CLOCK_SYNC_OUTPUT_ENABLE <= !power_down_bit || osc_keep_alive;
        end
    end

    // checks on the block's own behaviour
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    a_tone_forces_carrier: assert property (tx_enable_w && tx_on_bit |=> TX_CARRIER)
        else $error("carrier tone set but no carrier");
    a_idle_input_quiet: assert property (txd_s && !tx_on_bit |=> !TX_CARRIER)
        else $error("carrier sent with input high and tone off");
    a_standby_tx_off: assert property (standby_bit |=> !TX_CARRIER && !TX_CHAIN_ENABLE)
        else $error("transmit active in standby");
    a_powerdown_rx_off: assert property (power_down_bit |=> RX_DATA_OUT && !DIR)
        else $error("receive side active in power-down");
    a_osc_follows_keep: assert property (power_down_bit |=> OSC_ENABLE == $past(osc_keep_alive))
        else $error("oscillator enable does not follow keep bit");
    a_dir_no_echo: assert property (dir_st_r == mdsc_pkg::DIR_IDLE && tx_active_w |=> !DIR)
        else $error("own transmission raised direction");
    a_dir_rx_high: assert property (dir_st_r == mdsc_pkg::DIR_RECV && det_w |=> DIR)
        else $error("direction low while receiving");
    a_dir_dwell_len: assert property ($fell(DIR) && $past(dir_st_r) == mdsc_pkg::DIR_HOLD && !$past(power_down_bit)
        && $past(dir_per_w) != 13'h0000 |-> $past(hold_bits_r) == `MDSC_DIR_DWELL_BITS)
        else $error("direction dropped before sixteen bit times");
    a_launch_clears: assert property (scan_start_r |=> !scan_start_r)
        else $error("scan launch did not clear");
    a_scan_masked_port: assert property ($rose(scanning_w) |-> port_include_mask_r[scan_port_r])
        else $error("scan started on masked port");
    a_mux_follows_scan: assert property (scanning_w |=> MUX_PORT == $past(scan_port_r))
        else $error("multiplexer not on listened port");

    c_reg_write: cover property (wr_cfg_w);
    c_reg_read: cover property (rd_load_w ##[1:400] !csn_s && SDO_OE);
    c_dir_hold_done: cover property (dir_st_r == mdsc_pkg::DIR_HOLD ##1 dir_st_r == mdsc_pkg::DIR_IDLE);
    c_scan_done: cover property ($fell(scanning_w));

endmodule : mdsc_ctrl

// ===== test/mdsc_line_model.sv
// line-side partner: carrier detector and half-duplex bus transceiver
`timescale 1ns/1ps
module mdsc_line_model (
    // direction from the modem
    dir,
    // stimulus from the bench
    carrier_on,
    bus_data,
    // pins into the modem
    rx_detect,
    tx_data_in
);
    input  wire logic dir;
    input  wire logic carrier_on;
    input  wire logic bus_data;
    output wire logic rx_detect;
    output wire logic tx_data_in;

    // direction drives both enables: while high the receiver output is off
    // and the pulled-up line reads high, so stale bus data never leaks in
    assign tx_data_in = (dir === 1'b1) ? 1'b1 : bus_data;
    // detector follows the far-end carrier
    assign rx_detect = carrier_on;
endmodule : mdsc_line_model

// ===== test/mdsc_ctrl_bench.sv
// self-checking bench of the modem control block
`timescale 1ns/1ps
module mdsc_ctrl_bench;
    logic       CLOCK = 1'b0;
    logic       RESET = 1'b1;
    logic       SCLK = 1'b0;
    logic       SDI = 1'b0;
    logic       CHIP_SELECT_N = 1'b1;
    logic       carrier_on = 1'b0;
    logic       bus_data = 1'b1;
    logic       SDO, SDO_OE, TX_DATA_IN, RX_DETECT, RX_DATA_OUT, DIR;
    logic       TX_CARRIER, MUX_OPEN, TX_CHAIN_ENABLE, RX_CHAIN_ENABLE;
    logic       OSC_ENABLE, CLOCK_SYNC_OUTPUT_ENABLE;
    logic [3:0] TX_POWER_CODE, RX_SENS_CODE;
    logic [1:0] MUX_PORT;
    logic [7:0] rd_seen, v;
    logic [7:0] exp_q[$];
    event       rd_ev;
    int         mismatches = 0;
    int         comparisons = 0;
    int         bits[4] = '{20, 1302, 434, 0};

    // 50 MHz system clock
    always #10 CLOCK = ~CLOCK;

    // short bit time keeps the direction dwell affordable
    mdsc_ctrl #(.BIT_CYC_9K6(13'h14)) DUT
    (
        .CLOCK(CLOCK), .RESET(RESET), .SCLK(SCLK), .SDI(SDI),
        .CHIP_SELECT_N(CHIP_SELECT_N), .SDO(SDO), .SDO_OE(SDO_OE),
        .TX_DATA_IN(TX_DATA_IN), .RX_DETECT(RX_DETECT), .RX_DATA_OUT(RX_DATA_OUT),
        .DIR(DIR), .TX_CARRIER(TX_CARRIER), .TX_POWER_CODE(TX_POWER_CODE),
        .RX_SENS_CODE(RX_SENS_CODE), .MUX_PORT(MUX_PORT), .MUX_OPEN(MUX_OPEN),
        .TX_CHAIN_ENABLE(TX_CHAIN_ENABLE), .RX_CHAIN_ENABLE(RX_CHAIN_ENABLE),
        .OSC_ENABLE(OSC_ENABLE), .CLOCK_SYNC_OUTPUT_ENABLE(CLOCK_SYNC_OUTPUT_ENABLE)
    );

    mdsc_line_model line
    (
        .dir(DIR), .carrier_on(carrier_on), .bus_data(bus_data),
        .rx_detect(RX_DETECT), .tx_data_in(TX_DATA_IN)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    task automatic cyc(input int n);
        repeat (n) @(negedge CLOCK);
    endtask : cyc

    // one 16-bit frame; sdi moves mid-low so the synchronised edge sees it settled
    task automatic spi(input logic rw, input logic [6:0] a, input logic [7:0] d, input logic [7:0] e);
        logic [15:0] f;
        f = {rw, a, d};
        if (rw)
            exp_q.push_back(e);
        CHIP_SELECT_N = 1'b0;
        cyc(4);
        for (int i = 15; i >= 0; i--)
        begin
            cyc(2);
            SDI = f[i];
            cyc(2);
            SCLK = 1'b1;
            cyc(4);
            if (i < 8)
                rd_seen[i] = SDO;
            if (i == 0)
                check(SDO_OE, {7'h00, rw});
            SCLK = 1'b0;
        end
        cyc(4);
        CHIP_SELECT_N = 1'b1;
        cyc(6);
        check(SDO_OE, 8'h00);
        if (rw)
            -> rd_ev;
    endtask : spi

    // read results taken off the queue in order
    always @rd_ev check(rd_seen, exp_q.pop_front());

    initial
    begin
        void'($urandom(32'hD2DD6031));
        cyc(5);
        RESET = 1'b0;
        cyc(6);
        // reset values
        check({RX_SENS_CODE, TX_POWER_CODE}, 8'hB7);
        check({OSC_ENABLE, CLOCK_SYNC_OUTPUT_ENABLE}, 8'h03);
        spi(1'b1, 7'h00, 8'h00, 8'h80);
        spi(1'b1, 7'h02, 8'h00, 8'h0F);
        spi(1'b1, 7'h03, 8'h00, 8'hB7);
        // random write and read back of the transmit/receive register
        for (int k = 0; k < 3; k++)
        begin
            v = 8'($urandom);
            spi(1'b0, 7'h03, v, 8'h00);
            spi(1'b1, 7'h03, 8'h00, v);
            check({RX_SENS_CODE, TX_POWER_CODE}, v);
        end
        // status is read-only, unmapped reads zero
        spi(1'b0, 7'h07, 8'hFF, 8'h00);
        spi(1'b1, 7'h07, 8'h00, 8'h01);
        spi(1'b1, 7'h05, 8'h00, 8'h00);
        // own transmission with echoed carrier must not turn the line round
        bus_data = 1'b0;
        cyc(10);
        carrier_on = 1'b1;
        cyc(10);
        check({TX_CARRIER, DIR}, 8'h02);
        carrier_on = 1'b0;
        cyc(10);
        bus_data = 1'b1;
        cyc(10);
        check(TX_CARRIER, 8'h00);
        spi(1'b0, 7'h00, 8'h90, 8'h00);
        cyc(10);
        check(TX_CARRIER, 8'h01);
        // tone alone shows as transmit-active in status
        spi(1'b1, 7'h07, 8'h00, 8'h05);
        // direction dwell at every rate code
        for (int c = 0; c < 4; c++)
        begin
            spi(1'b0, 7'h00, 8'h80 | 8'(c), 8'h00);
            carrier_on = 1'b1;
            cyc(10);
            check({DIR, RX_DATA_OUT}, 8'h02);
            cyc(30);
            carrier_on = 1'b0;
            cyc(10);
            check(RX_DATA_OUT, 8'h01);
            if (c < 3)
            begin
                cyc(14 * bits[c]);
                check(DIR, 8'h01);
                cyc(2 * bits[c] + 30);
            end
            check(DIR, 8'h00);
        end
        // standby: transmit off, receive and direction alive
        spi(1'b0, 7'h00, 8'hA0, 8'h00);
        bus_data = 1'b0;
        cyc(10);
        check({TX_CHAIN_ENABLE, RX_CHAIN_ENABLE, TX_CARRIER}, 8'h02);
        bus_data = 1'b1;
        carrier_on = 1'b1;
        cyc(10);
        check({DIR, RX_DATA_OUT}, 8'h02);
        carrier_on = 1'b0;
        cyc(360);
        // power-down keeps the oscillator while the keep bit is set
        spi(1'b0, 7'h00, 8'hC0, 8'h00);
        carrier_on = 1'b1;
        cyc(10);
        check({RX_CHAIN_ENABLE, OSC_ENABLE, CLOCK_SYNC_OUTPUT_ENABLE, DIR, RX_DATA_OUT}, 8'h0D);
        carrier_on = 1'b0;
        spi(1'b1, 7'h00, 8'h00, 8'hC0);
        spi(1'b0, 7'h00, 8'h40, 8'h00);
        cyc(10);
        check({OSC_ENABLE, CLOCK_SYNC_OUTPUT_ENABLE}, 8'h00);
        spi(1'b0, 7'h00, 8'h80, 8'h00);
        cyc(10);
        check({OSC_ENABLE, TX_CHAIN_ENABLE, RX_CHAIN_ENABLE}, 8'h07);
        // scan over ports one and three only
        // manual port overridden while the scan runs; open bit always follows the register
        spi(1'b0, 7'h01, 8'h06, 8'h00);
        spi(1'b1, 7'h01, 8'h00, 8'h06);
        spi(1'b0, 7'h02, 8'h8A, 8'h00);
        cyc(10);
        check(MUX_PORT, 8'h01);
        spi(1'b1, 7'h02, 8'h00, 8'h5A);
        cyc(240);
        check(MUX_PORT, 8'h03);
        cyc(350);
        // listened-port keeps the last scanned port once the scan is over
        spi(1'b1, 7'h02, 8'h00, 8'h3A);
        cyc(10);
        check({MUX_OPEN, MUX_PORT}, 8'h06);
        results();
    end
endmodule : mdsc_ctrl_bench
